// file: hdl/dam_pkg.sv
// Overview of operation
// - output-2 analog gain resets to 8888h and holds default under any power-off or disable
// - output-1 digital mute bits at 15 (left) and 7 (right), one mutes
// - output-1 six-bit attenuation fields 13:8 and 5:0, 1.5 dB steps to -94.5 dB
// - output-2 digital mute bits at 15 (left) and 7 (right), one mutes
// - output-2 six-bit attenuation fields 13:8 and 5:0, 1.5 dB steps to -94.5 dB
// - both digital attenuation registers reset to 0000h and hold default while powered down
// - input-to-output-1 mix mute bits at 15 and 7, one mutes the path
// - mix attenuation six bits, 1.5 dB steps, 111110 is -93 dB, 111111 mutes
// - input-to-output-2 mix register has the same layout as the output-1 mix
// - both mix registers reset to 8080h and hold default while powered down
// - serial rate must be at least the conversion rate while a mix is used
// - rate source register holds selectors at 11:10, 9:8, 3:2 and 1:0
// - selector 00 is fixed 48 kHz, 01 to 11 pick rate generators 1 to 3
// - rate source register resets to 0000h and holds default while powered down
package dam_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_GAIN2 = 6'h0a;
  localparam logic [5:0] IDX_ATT1 = 6'h0b;
  localparam logic [5:0] IDX_ATT2 = 6'h0c;
  localparam logic [5:0] IDX_MIX1 = 6'h0d;
  localparam logic [5:0] IDX_MIX2 = 6'h0e;
  localparam logic [5:0] IDX_RATE = 6'h0f;
  localparam logic [5:0] IDX_STAT = 6'h10;

  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0006;
  localparam logic [15:0] GAIN2_RST = 16'h8888;
  localparam logic [15:0] ATT_RST = 16'h0000;
  localparam logic [15:0] MIX_RST = 16'h8080;
  localparam logic [15:0] RATE_RST = 16'h0000;

  // writable bits; reserved bits are dropped and read zero
  localparam logic [15:0] GAIN_MASK = 16'hbfbf;
  localparam logic [15:0] ATT_MASK = 16'hbfbf;
  localparam logic [15:0] RATE_MASK = 16'h0f0f;
  localparam logic [15:0] CTRL_MASK = 16'h0007;

  // field positions
  localparam int LEFT_MUTE = 15;
  localparam int RIGHT_MUTE = 7;
  localparam int LEFT_LSB = 8;
  localparam int RIGHT_LSB = 0;
  localparam int CODE_W = 6;
  localparam logic [5:0] FULL_MUTE = 6'h3f;
  localparam int OUT2_SRC_LSB = 10;
  localparam int OUT1_SRC_LSB = 8;
  localparam int IN_R_SRC_LSB = 2;
  localparam int IN_L_SRC_LSB = 0;
  localparam int CTRL_GPD = 0;
  localparam int CTRL_ANA_EN = 1;
  localparam int CTRL_OUT2_EN = 2;

  // gain of one 1.5 dB step inside a 6 dB octave, unsigned q15
  localparam logic [16:0] STEP_Q0 = 17'h0_8000;
  localparam logic [16:0] STEP_Q1 = 17'h0_6bb3;
  localparam logic [16:0] STEP_Q2 = 17'h0_5a9e;
  localparam logic [16:0] STEP_Q3 = 17'h0_4c3f;
  localparam int Q_SHIFT = 15;

  typedef struct packed {
    logic signed [15:0] l;
    logic signed [15:0] r;
  } dam_stereo_t;

  // one-hot per channel: bit0 fixed 48 kHz, bit1..3 rate generator 1..3
  typedef struct packed {
    logic [3:0] out2;
    logic [3:0] out1;
    logic [3:0] in_r;
    logic [3:0] in_l;
  } dam_rate_t;

endpackage : dam_pkg

// file: hdl/dam_top.sv
`timescale 1ns/1ps
`default_nettype none
module dam_top import dam_pkg::*; (
  input wire logic I_CLK, // 100 MHz clock
  input wire logic I_RST_N, // async reset pin, active low
  input wire logic I_POWERDOWN_PIN_N, // power-down pin, active low, asynchronous
  input wire logic I_WB_CYC, // wishbone cycle
  input wire logic I_WB_STB, // wishbone strobe
  input wire logic I_WB_WE, // wishbone write enable
  input wire logic [7:0] I_WB_ADR, // wishbone byte address
  input wire logic [31:0] I_WB_DAT, // wishbone write data
  input wire logic [3:0] I_WB_SEL, // wishbone byte selects
  output logic [31:0] O_WB_DAT, // wishbone read data
  output logic O_WB_ACK, // wishbone acknowledge
  input wire logic I_SAMPLE_STB, // one-cycle sample strobe
  input wire dam_stereo_t I_ADC, // converter input samples
  input wire dam_stereo_t I_DAC1, // output-1 input samples
  input wire dam_stereo_t I_DAC2, // output-2 input samples
  output var dam_stereo_t O_OUT1, // processed output-1 samples
  output var dam_stereo_t O_OUT2, // processed output-2 samples
  output logic O_SAMPLE_VLD, // pulse: new output samples
  output var dam_rate_t O_RATE // decoded rate sources
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (sel[0]) v[7:0] = wd[7:0];
    if (sel[1]) v[15:8] = wd[15:8];
    return v & mask;
  endfunction : merge

  function automatic logic signed [15:0] atten(input logic signed [15:0] s, input logic [5:0] c);
    logic [16:0] m;
    logic signed [33:0] p;
    logic signed [33:0] q;
    case (c[1:0])
      2'd0: m = STEP_Q0;
      2'd1: m = STEP_Q1;
      2'd2: m = STEP_Q2;
      default: m = STEP_Q3;
    endcase
    p = 34'(s) * $signed({1'b0, m});
    q = (p >>> Q_SHIFT) >>> c[5:2];
    return q[15:0];
  endfunction : atten

  function automatic logic signed [15:0] sat(input logic signed [16:0] v);
    if (v > 17'sd32767) return 16'sh7fff;
    if (v < -17'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction : sat

  function automatic logic [3:0] rate_dec(input logic [1:0] s);
    return 4'b0001 << s;
  endfunction : rate_dec

  // one channel: attenuation, then the mix term; the digital mute zeroes the whole sum, mix included
  function automatic logic signed [15:0] chan(input logic signed [15:0] d, input logic dmute,
                                              input logic [5:0] dcode, input logic signed [15:0] a,
                                              input logic mmute, input logic [5:0] mcode);
    logic signed [15:0] mix;
    mix = (mmute || mcode == FULL_MUTE) ? 16'sh0000 : atten(a, mcode);
    if (dmute) return 16'sh0000;
    return sat(17'(atten(d, dcode)) + 17'(mix));
  endfunction : chan

  ////////////////////////////////////////////////////////////////////////////
  // power-down pin synchroniser and hold conditions

  logic pd_meta;
  logic pd_sync;
  logic [15:0] ctrl;
  logic [15:0] gain2;
  logic [15:0] att1;
  logic [15:0] att2;
  logic [15:0] mix1;
  logic [15:0] mix2;
  logic [15:0] rate_src;
  logic hold;
  logic hold_gain;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pd_meta <= 1'b0;
      pd_sync <= 1'b0;
    end else begin
      pd_meta <= I_POWERDOWN_PIN_N;
      pd_sync <= pd_meta;
    end
  end

  assign hold = !pd_sync || ctrl[CTRL_GPD];
  assign hold_gain = hold || !ctrl[CTRL_ANA_EN] || !ctrl[CTRL_OUT2_EN];

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, unmapped reads zero, writes dropped

  logic req;
  logic wr;
  logic [5:0] idx;
  logic [15:0] rd;

  assign req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wr = req && I_WB_WE;
  assign idx = I_WB_ADR[7:2];

  always_comb begin
    case (idx)
      IDX_CTRL: rd = ctrl;
      IDX_GAIN2: rd = gain2;
      IDX_ATT1: rd = att1;
      IDX_ATT2: rd = att2;
      IDX_MIX1: rd = mix1;
      IDX_MIX2: rd = mix2;
      IDX_RATE: rd = rate_src;
      IDX_STAT: rd = {8'h00, !mix2[RIGHT_MUTE], !mix2[LEFT_MUTE], !mix1[RIGHT_MUTE],
                      !mix1[LEFT_MUTE], 2'b00, hold_gain, hold};
      default: rd = 16'h0000;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end else begin
      O_WB_ACK <= req;
      O_WB_DAT <= (req && !I_WB_WE) ? {16'h0000, rd} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl <= CTRL_RST;
    end else if (wr && idx == IDX_CTRL) begin
      ctrl <= merge(ctrl, I_WB_DAT, I_WB_SEL, CTRL_MASK);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      gain2 <= GAIN2_RST;
    end else if (hold_gain) begin
      gain2 <= GAIN2_RST;
    end else if (wr && idx == IDX_GAIN2) begin
      gain2 <= merge(gain2, I_WB_DAT, I_WB_SEL, GAIN_MASK);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      att1 <= ATT_RST;
      att2 <= ATT_RST;
    end else if (hold) begin
      att1 <= ATT_RST;
      att2 <= ATT_RST;
    end else if (wr && idx == IDX_ATT1) begin
      att1 <= merge(att1, I_WB_DAT, I_WB_SEL, ATT_MASK);
    end else if (wr && idx == IDX_ATT2) begin
      att2 <= merge(att2, I_WB_DAT, I_WB_SEL, ATT_MASK);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mix1 <= MIX_RST;
      mix2 <= MIX_RST;
    end else if (hold) begin
      mix1 <= MIX_RST;
      mix2 <= MIX_RST;
    end else if (wr && idx == IDX_MIX1) begin
      mix1 <= merge(mix1, I_WB_DAT, I_WB_SEL, ATT_MASK);
    end else if (wr && idx == IDX_MIX2) begin
      mix2 <= merge(mix2, I_WB_DAT, I_WB_SEL, ATT_MASK);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rate_src <= RATE_RST;
    end else if (hold) begin
      rate_src <= RATE_RST;
    end else if (wr && idx == IDX_RATE) begin
      rate_src <= merge(rate_src, I_WB_DAT, I_WB_SEL, RATE_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate source decode

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RATE <= '0;
    end else begin
      O_RATE.out2 <= rate_dec(rate_src[OUT2_SRC_LSB +: 2]);
      O_RATE.out1 <= rate_dec(rate_src[OUT1_SRC_LSB +: 2]);
      O_RATE.in_r <= rate_dec(rate_src[IN_R_SRC_LSB +: 2]);
      O_RATE.in_l <= rate_dec(rate_src[IN_L_SRC_LSB +: 2]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample path; mixing assumes a shared rate generator for input and output

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_OUT1 <= '0;
      O_OUT2 <= '0;
      O_SAMPLE_VLD <= 1'b0;
    end else begin
      O_SAMPLE_VLD <= I_SAMPLE_STB;
      if (I_SAMPLE_STB) begin
        O_OUT1.l <= chan(I_DAC1.l, att1[LEFT_MUTE], att1[LEFT_LSB +: CODE_W], I_ADC.l,
                         mix1[LEFT_MUTE], mix1[LEFT_LSB +: CODE_W]);
        O_OUT1.r <= chan(I_DAC1.r, att1[RIGHT_MUTE], att1[RIGHT_LSB +: CODE_W], I_ADC.r,
                         mix1[RIGHT_MUTE], mix1[RIGHT_LSB +: CODE_W]);
        O_OUT2.l <= chan(I_DAC2.l, att2[LEFT_MUTE], att2[LEFT_LSB +: CODE_W], I_ADC.l,
                         mix2[LEFT_MUTE], mix2[LEFT_LSB +: CODE_W]);
        O_OUT2.r <= chan(I_DAC2.r, att2[RIGHT_MUTE], att2[RIGHT_LSB +: CODE_W], I_ADC.r,
                         mix2[RIGHT_MUTE], mix2[RIGHT_LSB +: CODE_W]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_req;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence

  sequence s_ack_once;
    O_WB_ACK ##1 !O_WB_ACK;
  endsequence

  property p_ack_once;
    @(posedge I_CLK) disable iff (!I_RST_N)
    s_req |=> s_ack_once;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse after request");

  property p_gain_hold;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (!pd_sync || ctrl[CTRL_GPD] || !ctrl[CTRL_ANA_EN] || !ctrl[CTRL_OUT2_EN]) |=> gain2 == GAIN2_RST;
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain register left default while held");

  property p_att_hold;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (!pd_sync || ctrl[CTRL_GPD]) |=> (att1 == 16'h0000 && att2 == 16'h0000);
  endproperty
  a_att_hold: assert property (p_att_hold) else $error("attenuation not default in power-down");

  property p_mix_hold;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (!pd_sync || ctrl[CTRL_GPD]) |=> (mix1 == 16'h8080 && mix2 == 16'h8080);
  endproperty
  a_mix_hold: assert property (p_mix_hold) else $error("mix not default in power-down");

  property p_rate_hold;
    @(posedge I_CLK) disable iff (!I_RST_N)
    hold |=> rate_src == 16'h0000 ##1 O_RATE == 16'h1111;
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("rate source not default in power-down");

  property p_att_write;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (wr && idx == IDX_ATT1 && I_WB_SEL[1:0] == 2'b11 && !hold) |=> att1 == ($past(I_WB_DAT[15:0]) & 16'hbfbf);
  endproperty
  a_att_write: assert property (p_att_write) else $error("attenuation write not stored");

  property p_mute_zero;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_SAMPLE_STB && att1[15] && att2[7]) |=> (O_OUT1.l == 16'sh0000 && O_OUT2.r == 16'sh0000 && O_SAMPLE_VLD);
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("muted channel not zero");

  property p_mix_full_mute;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_SAMPLE_STB && mix1[13:8] == 6'h3f && att1[15:8] == 8'h00) |=> O_OUT1.l == $past(I_DAC1.l);
  endproperty
  a_mix_full_mute: assert property (p_mix_full_mute) else $error("full-mute mix code leaked");

  property p_rate_dec;
    @(posedge I_CLK) disable iff (!I_RST_N)
    rate_src[9:8] == 2'b00 |=> (O_RATE.out1 == 4'b0001);
  endproperty
  a_rate_dec: assert property (p_rate_dec) else $error("selector 00 not decoded as 48 kHz");

  property p_mix_add;
    @(posedge I_CLK) disable iff (!I_RST_N)
    (I_SAMPLE_STB && mix2[15:8] == 8'h00 && att2[15:8] == 8'h00 && I_DAC2.l == 16'sh0000)
      |=> O_OUT2.l == $past(I_ADC.l);
  endproperty
  a_mix_add: assert property (p_mix_add) else $error("unmuted mix not added");

endmodule : dam_top
`default_nettype wire

// file: bench/dam_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dam_top_tb import dam_pkg::*;;
  logic clk;
  logic rst_n;
  logic pdn_n;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [3:0] sel;
  logic [31:0] rdat;
  logic ack;
  logic smp_stb;
  dam_stereo_t adc;
  dam_stereo_t dac1;
  dam_stereo_t dac2;
  dam_stereo_t out1;
  dam_stereo_t out2;
  logic smp_vld;
  dam_rate_t rate;
  int fail_count;
  int n_checks;
  int cycles;

  dam_top dam_top_inst (
    .I_CLK(clk), .I_RST_N(rst_n), .I_POWERDOWN_PIN_N(pdn_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_SAMPLE_STB(smp_stb), .I_ADC(adc), .I_DAC1(dac1), .I_DAC2(dac2), .O_OUT1(out1), .O_OUT2(out2),
    .O_SAMPLE_VLD(smp_vld), .O_RATE(rate)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // classic single cycle; one idle cycle always precedes the request
  task automatic wb_xfer(input logic w, input logic [5:0] idx, input logic [15:0] d, input logic [3:0] s,
                         output logic [31:0] rd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {16'h0000, d};
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    logic [31:0] rd;
    wb_xfer(1'b1, idx, d, 4'b0011, rd);
  endtask : wr

  task automatic rdchk(input logic [5:0] idx, input logic [15:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, idx, 16'h0000, 4'b0011, rd);
    check(rd, {16'h0000, exp});
  endtask : rdchk

  // one strobe; outputs are judged one cycle later
  task automatic sample(input logic [31:0] e1, input logic [31:0] e2);
    @(posedge clk);
    smp_stb <= 1'b1;
    @(posedge clk);
    smp_stb <= 1'b0;
    #1;
    check({31'h0000_0000, smp_vld}, 32'h0000_0001);
    check(out1, e1);
    check(out2, e2);
  endtask : sample

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    check({16'h0000, rate}, 32'h0000_1111);
    rdchk(IDX_ATT1, 16'h0000);
    rdchk(IDX_ATT2, 16'h0000);
    rdchk(IDX_MIX1, 16'h8080);
    rdchk(IDX_MIX2, 16'h8080);
    rdchk(IDX_RATE, 16'h0000);
    rdchk(IDX_GAIN2, 16'h8888);
  endtask : t_reset_values

  task automatic t_layout;
    logic [31:0] rd;
    wr(IDX_ATT1, 16'hbfbf);
    rdchk(IDX_ATT1, 16'hbfbf);
    wb_xfer(1'b1, IDX_ATT2, 16'hbfbf, 4'b0001, rd);
    rdchk(IDX_ATT2, 16'h00bf);
    wr(IDX_RATE, 16'h0f0f);
    rdchk(IDX_RATE, 16'h0f0f);
    rdchk(6'h3e, 16'h0000);
    // out2 = gen3, out1 = gen2, in right = gen1, in left = fixed rate
    wr(IDX_RATE, 16'h0e04);
    @(posedge clk);
    #1;
    check({16'h0000, rate}, 32'h0000_8421);
  endtask : t_layout

  task automatic t_datapath;
    wr(IDX_RATE, 16'h0505);
    adc <= '{l: 16'h0100, r: 16'h0100};
    dac1 <= '{l: 16'h0400, r: 16'h0400};
    dac2 <= '{l: 16'h0800, r: 16'hfc00};
    wr(IDX_ATT1, 16'h8004);
    wr(IDX_ATT2, 16'h0000);
    wr(IDX_MIX1, 16'h003f);
    sample({16'h0000, 16'h0200}, {16'h0800, 16'hfc00});
    wr(IDX_MIX2, 16'h0008);
    sample({16'h0000, 16'h0200}, {16'h0900, 16'hfc40});
    wr(IDX_ATT1, 16'h0000);
    wr(IDX_MIX1, 16'h8000);
    sample({16'h0400, 16'h0500}, {16'h0900, 16'hfc40});
    wr(IDX_ATT2, 16'h0080);
    wr(IDX_ATT1, 16'h8000);
    sample({16'h0000, 16'h0500}, {16'h0900, 16'h0000});
    wr(IDX_ATT1, 16'h0000);
    wr(IDX_MIX1, 16'h3f00);
    dac2 <= '{l: 16'h0000, r: 16'hfc00};
    sample({16'h0400, 16'h0500}, {16'h0100, 16'h0000});
  endtask : t_datapath

  task automatic t_hold;
    wr(IDX_CTRL, 16'h0007);
    rdchk(IDX_STAT, 16'h0003);
    rdchk(IDX_ATT2, 16'h0000);
    wr(IDX_MIX1, 16'h0000);
    rdchk(IDX_MIX1, 16'h8080);
    wr(IDX_CTRL, 16'h0006);
    wr(IDX_GAIN2, 16'h0101);
    rdchk(IDX_GAIN2, 16'h0101);
    wr(IDX_CTRL, 16'h0004);
    rdchk(IDX_GAIN2, 16'h8888);
    wr(IDX_CTRL, 16'h0006);
    wr(IDX_RATE, 16'h0505);
    rdchk(IDX_RATE, 16'h0505);
    @(posedge clk);
    pdn_n <= 1'b0;
    repeat (3) @(posedge clk);
    wr(IDX_ATT1, 16'h0303);
    rdchk(IDX_ATT1, 16'h0000);
    rdchk(IDX_RATE, 16'h0000);
    check({16'h0000, rate}, 32'h0000_1111);
    @(posedge clk);
    pdn_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr(IDX_ATT1, 16'h0303);
    rdchk(IDX_ATT1, 16'h0303);
  endtask : t_hold

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      $display("unexpected at %0t: run did not finish", $time);
      end_sim();
    end
  end

  initial begin
    fail_count = 0;
    n_checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    pdn_n = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    sel = 4'h0;
    smp_stb = 1'b0;
    adc = '0;
    dac1 = '0;
    dac2 = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset_values();
    t_layout();
    t_datapath();
    t_hold();
    end_sim();
  end
endmodule : dam_top_tb
`default_nettype wire
